// *** src/vxs_pkg.sv ***
// constants and types of the voltage transformer supervision block
// --------------------------------------------------------------------
// --------------------------------------------------------------------
package vxs_pkg;
  // timing
  localparam int unsigned CLK_FREQ_MHZ = 200;
  localparam int unsigned MEAS_BASE_NS = 5000000;
  localparam int unsigned TICK_CYCLES = MEAS_BASE_NS * CLK_FREQ_MHZ / 1000;
  localparam int unsigned ANGLE_WINDOW_NS = 40000000;
  localparam int unsigned HIST_DEPTH = ANGLE_WINDOW_NS / MEAS_BASE_NS;
  localparam int unsigned BLOCK_LEAD_NS = 5000000;
  // widths
  localparam int unsigned MAG_W = 16;
  localparam int unsigned ANG_W = 16;
  localparam int unsigned DLY_W = 19;
  localparam int unsigned REM_W = 20;
  localparam int unsigned ADDR_W = 8;
  // angles in 0.01 deg
  localparam logic [15:0] ANG_FULL = 16'h8CA0;
  localparam logic [15:0] ANG_HALF = 16'h4650;
  localparam logic [15:0] SEQ_LAG = 16'h2EE0;
  localparam logic [15:0] SEQ_LEAD = 16'h5DC0;
  localparam logic [15:0] SEQ_TOL = 16'h05DC;
  // register offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_G0_THR = 8'h04;
  localparam logic [7:0] OFF_G0_ANG = 8'h08;
  localparam logic [7:0] OFF_G0_DLY = 8'h0C;
  localparam logic [7:0] OFF_G1_THR = 8'h10;
  localparam logic [7:0] OFF_G1_ANG = 8'h14;
  localparam logic [7:0] OFF_G1_DLY = 8'h18;
  localparam logic [7:0] OFF_STATUS = 8'h1C;
  localparam logic [7:0] OFF_EXPTIME = 8'h20;
  localparam logic [7:0] OFF_REMAIN = 8'h24;
  // fields and reset values
  localparam int unsigned CTRL_GRP = 0;
  localparam int unsigned CTRL_BUSCHK = 1;
  localparam int unsigned CTRL_LINECHK = 2;
  localparam int unsigned THR_HIGH_LSB = 16;
  localparam int unsigned ST_COND_LSB = 4;
  localparam int unsigned ST_FLAG_LSB = 12;
  localparam int unsigned ST_LOW_LSB = 20;
  localparam int unsigned ST_HIGH_LSB = 24;
  localparam logic [15:0] LOW_RST = 16'h0005;
  localparam logic [15:0] HIGH_RST = 16'h0050;
  localparam logic [15:0] ANGLE_RST = 16'h01F4;
  localparam logic [18:0] DLY_RST = 19'h000C8;
  localparam logic signed [19:0] REM_MIN = -20'sh57E40;
  // bus voltage status codes, register response codes and condition codes
  localparam logic [2:0] BUS_DEAD = 3'h0;
  localparam logic [2:0] BUS_OK = 3'h1;
  localparam logic [2:0] BUS_REV = 3'h2;
  localparam logic [2:0] BUS_UNDEF = 3'h3;
  localparam logic [2:0] BUS_PROBLEM = 3'h4;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [4:0] {
    COND_NORMAL = 5'h01,
    COND_START = 5'h02,
    COND_LINE = 5'h04,
    COND_BUS = 5'h08,
    COND_BLOCKED = 5'h10
  } vxs_cond_t;
endpackage

// *** src/vxs_supervision.sv ***
// voltage transformer supervision core with AXI4-Lite registers
`timescale 1ns/100ps
`default_nettype none
module vxs_supervision #(
  parameter int unsigned TICK_CYCLES = vxs_pkg::TICK_CYCLES
) (
  input wire logic core_clk, // system clock
  input wire logic arst_n, // async reset
  input wire logic [7:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // byte strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [7:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read valid
  input wire logic s_axi_rready, // read ready
  input wire logic [15:0] volt1Mag, // channel 1 magnitude
  input wire logic [15:0] volt2Mag, // channel 2 magnitude
  input wire logic [15:0] volt3Mag, // channel 3 magnitude
  input wire logic [15:0] volt4Mag, // channel 4 (line) magnitude
  input wire logic [15:0] volt1Ang, // channel 1 angle
  input wire logic [15:0] volt2Ang, // channel 2 angle
  input wire logic [15:0] volt3Ang, // channel 3 angle
  input wire logic [15:0] volt4Ang, // channel 4 angle
  input wire logic blockIn, // blocking matrix input
  input wire logic busBreakerTripInput, // bus breaker trip
  input wire logic lineBreakerTripInput, // line breaker trip
  output logic startOut, // start active
  output logic blockedOut, // blocked active
  output logic busXfmrFailure, // bus transformer failure
  output logic lineXfmrFailure, // line transformer failure
  output logic busFuseFailure, // bus fuse failure
  output logic lineFuseFailure, // line fuse failure
  output logic [2:0] busVoltState, // bus voltage status
  output logic [4:0] condState // condition, one-hot
);
  localparam int unsigned TW = $clog2(TICK_CYCLES + 1);
  localparam int unsigned HD = vxs_pkg::HIST_DEPTH;

  // --------------------------------------------------------------
  // reset release and pin synchronisers
  // --------------------------------------------------------------
  logic [1:0] rstPipeQ;
  logic rstN;
  logic [2:0] syncAQ, syncBQ;
  logic blkSync, busTripSync, lineTripSync;

  // reset released through two flops
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) rstPipeQ <= 2'h0;
    else rstPipeQ <= {rstPipeQ[0], 1'b1};
  end
  assign rstN = rstPipeQ[1];

  // two flops per pin
  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      syncAQ <= 3'h0;
      syncBQ <= 3'h0;
    end else begin
      syncAQ <= {lineBreakerTripInput, busBreakerTripInput, blockIn};
      syncBQ <= syncAQ;
    end
  end
  assign blkSync = syncBQ[0];
  assign busTripSync = syncBQ[1];
  assign lineTripSync = syncBQ[2];

  // --------------------------------------------------------------
  // measurement time base
  // --------------------------------------------------------------
  logic [TW-1:0] tickCntQ;
  logic tick;

  assign tick = (tickCntQ == TW'(TICK_CYCLES - 1));
  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) tickCntQ <= '0;
    else tickCntQ <= tick ? '0 : tickCntQ + TW'(1);
  end

  // --------------------------------------------------------------
  // register bus
  // --------------------------------------------------------------
  logic awHeldQ, wHeldQ, bvalidQ, rvalidQ;
  logic [7:0] awAddrQ;
  logic [31:0] wDataQ, rdataQ;
  logic [3:0] wStrbQ;
  logic [1:0] brespQ, rrespQ;
  logic doWrite, arTake;
  logic [7:0] wAddr, rAddr;
  logic wrHit, rdHit;
  logic [31:0] rdWord, statusWord;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) if (strb[b]) r[b*8 +: 8] = nw[b*8 +: 8];
    return r;
  endfunction

  // channel handshakes
  assign s_axi_awready = !awHeldQ && !bvalidQ;
  assign s_axi_wready = !wHeldQ && !bvalidQ;
  assign s_axi_arready = !rvalidQ;
  assign doWrite = awHeldQ && wHeldQ && !bvalidQ;
  assign arTake = s_axi_arvalid && !rvalidQ;
  assign wAddr = {awAddrQ[7:2], 2'b00};
  assign rAddr = {s_axi_araddr[7:2], 2'b00};
  assign wrHit = (wAddr <= vxs_pkg::OFF_G1_DLY);
  assign rdHit = (rAddr <= vxs_pkg::OFF_REMAIN);

  // write address and data latch
  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      awHeldQ <= 1'b0;
      wHeldQ <= 1'b0;
      awAddrQ <= 8'h00;
      wDataQ <= 32'h0000_0000;
      wStrbQ <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeldQ <= 1'b1;
        awAddrQ <= s_axi_awaddr;
      end else if (doWrite) awHeldQ <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) begin
        wHeldQ <= 1'b1;
        wDataQ <= s_axi_wdata;
        wStrbQ <= s_axi_wstrb;
      end else if (doWrite) wHeldQ <= 1'b0;
    end
  end

  // write and read responses
  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      bvalidQ <= 1'b0;
      brespQ <= vxs_pkg::RESP_OKAY;
      rvalidQ <= 1'b0;
      rdataQ <= 32'h0000_0000;
      rrespQ <= vxs_pkg::RESP_OKAY;
    end else begin
      if (doWrite) begin
        bvalidQ <= 1'b1;
        brespQ <= wrHit ? vxs_pkg::RESP_OKAY : vxs_pkg::RESP_SLVERR;
      end else if (s_axi_bready) bvalidQ <= 1'b0;
      if (arTake) begin
        rvalidQ <= 1'b1;
        rdataQ <= rdWord;
        rrespQ <= rdHit ? vxs_pkg::RESP_OKAY : vxs_pkg::RESP_SLVERR;
      end else if (s_axi_rready) rvalidQ <= 1'b0;
    end
  end
  assign s_axi_bvalid = bvalidQ;
  assign s_axi_bresp = brespQ;
  assign s_axi_rvalid = rvalidQ;
  assign s_axi_rdata = rdataQ;
  assign s_axi_rresp = rrespQ;

  // --------------------------------------------------------------
  // settings, two groups
  // --------------------------------------------------------------
  logic [31:0] ctrlQ;
  logic [31:0] thrQ [2];
  logic [31:0] angQ [2];
  logic [31:0] dlyQ [2];
  logic grpSel, busChk, lineChk;
  logic [15:0] actLow, actHigh, actAng;
  logic [18:0] actDly;

  // settings writable at any time
  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      ctrlQ <= 32'h0000_0006;
      for (int g = 0; g < 2; g++) begin
        thrQ[g] <= {vxs_pkg::HIGH_RST, vxs_pkg::LOW_RST};
        angQ[g] <= {16'h0000, vxs_pkg::ANGLE_RST};
        dlyQ[g] <= {13'h0000, vxs_pkg::DLY_RST};
      end
    end else if (doWrite) begin
      unique case (wAddr)
        vxs_pkg::OFF_CTRL: ctrlQ <= merge(ctrlQ, wDataQ, wStrbQ) & 32'h0000_0007;
        vxs_pkg::OFF_G0_THR: thrQ[0] <= merge(thrQ[0], wDataQ, wStrbQ);
        vxs_pkg::OFF_G0_ANG: angQ[0] <= merge(angQ[0], wDataQ, wStrbQ) & 32'h0000_FFFF;
        vxs_pkg::OFF_G0_DLY: dlyQ[0] <= merge(dlyQ[0], wDataQ, wStrbQ) & 32'h0007_FFFF;
        vxs_pkg::OFF_G1_THR: thrQ[1] <= merge(thrQ[1], wDataQ, wStrbQ);
        vxs_pkg::OFF_G1_ANG: angQ[1] <= merge(angQ[1], wDataQ, wStrbQ) & 32'h0000_FFFF;
        vxs_pkg::OFF_G1_DLY: dlyQ[1] <= merge(dlyQ[1], wDataQ, wStrbQ) & 32'h0007_FFFF;
        default: ;
      endcase
    end
  end

  // active group switch, no restart of the function
  assign grpSel = ctrlQ[vxs_pkg::CTRL_GRP];
  assign busChk = ctrlQ[vxs_pkg::CTRL_BUSCHK];
  assign lineChk = ctrlQ[vxs_pkg::CTRL_LINECHK];
  assign actLow = thrQ[grpSel][15:0];
  assign actHigh = thrQ[grpSel][vxs_pkg::THR_HIGH_LSB +: 16];
  assign actAng = angQ[grpSel][15:0];
  assign actDly = dlyQ[grpSel][18:0];

  // --------------------------------------------------------------
  // measurement sampling and angle history
  // --------------------------------------------------------------
  logic [15:0] magIn [4];
  logic [15:0] angIn [4];
  logic [15:0] magQ [4];
  logic [15:0] curAngQ [4];
  logic [15:0] histQ [4][HD];
  logic [3:0] shiftOver;

  function automatic logic [15:0] fwdDiff(input logic [15:0] a, input logic [15:0] b);
    return (b >= a) ? b - a : 16'(b + vxs_pkg::ANG_FULL - a);
  endfunction
  function automatic logic [15:0] angDist(input logic [15:0] a, input logic [15:0] b);
    logic [15:0] d;
    d = fwdDiff(a, b);
    return (d > vxs_pkg::ANG_HALF) ? 16'(vxs_pkg::ANG_FULL - d) : d;
  endfunction

  assign magIn = '{volt1Mag, volt2Mag, volt3Mag, volt4Mag};
  assign angIn = '{volt1Ang, volt2Ang, volt3Ang, volt4Ang};

  // sample every time base, shift angle history
  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      for (int c = 0; c < 4; c++) begin
        magQ[c] <= 16'h0000;
        curAngQ[c] <= 16'h0000;
        for (int k = 0; k < HD; k++) histQ[c][k] <= 16'h0000;
      end
    end else if (tick) begin
      for (int c = 0; c < 4; c++) begin
        magQ[c] <= magIn[c];
        curAngQ[c] <= angIn[c];
        histQ[c][0] <= curAngQ[c];
        for (int k = 1; k < HD; k++) histQ[c][k] <= histQ[c][k-1];
      end
    end
  end

  // present angle against the one a window earlier
  for (genvar c = 0; c < 4; c++) begin : g_shift
    assign shiftOver[c] = angDist(histQ[c][HD-1], curAngQ[c]) >= actAng;
  end

  // --------------------------------------------------------------
  // pick-up, sequence, bus status
  // --------------------------------------------------------------
  logic [2:0] lowFlag, highFlag;
  logic pickRaw, pickQual, shiftSeen, busDead, inLimits, lineLoc;
  logic seqFwd, seqRev;
  logic [15:0] d21, d31;
  logic [2:0] busStateD, busStateQ;

  // per-phase threshold ratio tests
  for (genvar p = 0; p < 3; p++) begin : g_cmp
    assign lowFlag[p] = magQ[p] < actLow;
    assign highFlag[p] = magQ[p] > actHigh;
  end
  assign pickRaw = (|lowFlag)
    || (highFlag[0] && highFlag[1]) || (highFlag[0] && highFlag[2])
    || (highFlag[1] && highFlag[2]);
  assign shiftSeen = |shiftOver[2:0];
  assign pickQual = pickRaw && (shiftSeen || startOut);
  assign busDead = &lowFlag;
  assign inLimits = !(|lowFlag) && !(|highFlag);
  assign lineLoc = magQ[3] < actLow;
  assign d21 = fwdDiff(curAngQ[0], curAngQ[1]);
  assign d31 = fwdDiff(curAngQ[0], curAngQ[2]);
  assign seqFwd = angDist(d21, vxs_pkg::SEQ_LEAD) <= vxs_pkg::SEQ_TOL
    && angDist(d31, vxs_pkg::SEQ_LAG) <= vxs_pkg::SEQ_TOL;
  assign seqRev = angDist(d21, vxs_pkg::SEQ_LAG) <= vxs_pkg::SEQ_TOL
    && angDist(d31, vxs_pkg::SEQ_LEAD) <= vxs_pkg::SEQ_TOL;

  // five-valued bus status
  assign busStateD = busDead ? vxs_pkg::BUS_DEAD :
    pickRaw ? vxs_pkg::BUS_PROBLEM :
    !inLimits ? vxs_pkg::BUS_PROBLEM :
    seqFwd ? vxs_pkg::BUS_OK :
    seqRev ? vxs_pkg::BUS_REV :
    vxs_pkg::BUS_UNDEF;
  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) busStateQ <= vxs_pkg::BUS_DEAD;
    else busStateQ <= busStateD;
  end
  assign busVoltState = busStateQ;

  // --------------------------------------------------------------
  // start, blocking and definite-time countdown
  // --------------------------------------------------------------
  logic startQ, blockedQ, busFailQ, lineFailQ;
  logic signed [19:0] remainQ;
  logic signed [19:0] dlyS;
  logic [18:0] expTimeQ;
  logic runTick;

  assign dlyS = signed'({1'b0, actDly});
  assign runTick = tick && pickQual && !blkSync;

  // processed once per time base with the blocking level of that cycle
  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      startQ <= 1'b0;
      blockedQ <= 1'b0;
      busFailQ <= 1'b0;
      lineFailQ <= 1'b0;
      remainQ <= '0;
    end else if (tick) begin
      if (!runTick) begin
        startQ <= 1'b0;
        busFailQ <= 1'b0;
        lineFailQ <= 1'b0;
        remainQ <= dlyS;
        blockedQ <= pickQual && blkSync;
      end else begin
        blockedQ <= 1'b0;
        startQ <= 1'b1;
        if (!startQ) remainQ <= dlyS;
        else begin
          if (remainQ > vxs_pkg::REM_MIN) remainQ <= remainQ - 20'sd1;
          if (remainQ <= 20'sd1 && !busFailQ && !lineFailQ) begin
            lineFailQ <= lineLoc;
            busFailQ <= !lineLoc;
          end
        end
      end
    end
  end

  // expected operating time follows the active delay
  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) expTimeQ <= vxs_pkg::DLY_RST;
    else expTimeQ <= actDly;
  end

  // fuse failures, level from the synchronised trip inputs
  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      busFuseFailure <= 1'b0;
      lineFuseFailure <= 1'b0;
    end else begin
      busFuseFailure <= busChk && busTripSync;
      lineFuseFailure <= lineChk && lineTripSync;
    end
  end

  assign startOut = startQ;
  assign blockedOut = blockedQ;
  assign busXfmrFailure = busFailQ;
  assign lineXfmrFailure = lineFailQ;
  assign condState = blockedQ ? vxs_pkg::COND_BLOCKED :
    busFailQ ? vxs_pkg::COND_BUS :
    lineFailQ ? vxs_pkg::COND_LINE :
    startQ ? vxs_pkg::COND_START : vxs_pkg::COND_NORMAL;

  // --------------------------------------------------------------
  // read mux
  // --------------------------------------------------------------
  assign statusWord = {5'h00, highFlag, 1'b0, lowFlag, shiftSeen, pickRaw,
    lineFuseFailure, busFuseFailure, lineFailQ, busFailQ, blockedQ, startQ,
    3'h0, condState, 1'b0, busStateQ};
  assign rdWord = (rAddr == vxs_pkg::OFF_CTRL) ? ctrlQ :
    (rAddr == vxs_pkg::OFF_G0_THR) ? thrQ[0] :
    (rAddr == vxs_pkg::OFF_G0_ANG) ? angQ[0] :
    (rAddr == vxs_pkg::OFF_G0_DLY) ? dlyQ[0] :
    (rAddr == vxs_pkg::OFF_G1_THR) ? thrQ[1] :
    (rAddr == vxs_pkg::OFF_G1_ANG) ? angQ[1] :
    (rAddr == vxs_pkg::OFF_G1_DLY) ? dlyQ[1] :
    (rAddr == vxs_pkg::OFF_STATUS) ? statusWord :
    (rAddr == vxs_pkg::OFF_EXPTIME) ? {13'h0000, expTimeQ} :
    (rAddr == vxs_pkg::OFF_REMAIN) ? {{12{remainQ[19]}}, remainQ} : 32'h0000_0000;

  // --------------------------------------------------------------
  // checks
  // --------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstN);

  sequence s_freeTick;
    tick && pickQual && !blkSync;
  endsequence
  sequence s_blockTick;
    tick && pickQual && blkSync;
  endsequence

  property p_startOnPick;
    s_freeTick |=> startOut && !blockedOut;
  endproperty
  a_startOnPick: assert property (p_startOnPick) else $error("start not raised");
  property p_blockOnPick;
    s_blockTick |=> blockedOut && !startOut && condState == vxs_pkg::COND_BLOCKED;
  endproperty
  a_blockOnPick: assert property (p_blockOnPick) else $error("blocked not raised");
  property p_release;
    (tick && startOut && blkSync) |=> !startOut && !busXfmrFailure && !lineXfmrFailure;
  endproperty
  a_release: assert property (p_release) else $error("start not released");
  property p_loadDelay;
    (s_freeTick and !startOut) |=> remainQ == $past(dlyS);
  endproperty
  a_loadDelay: assert property (p_loadDelay) else $error("delay not loaded");
  property p_countDown;
    (s_freeTick and startOut && remainQ > vxs_pkg::REM_MIN) |=> remainQ == $past(remainQ) - 1;
  endproperty
  a_countDown: assert property (p_countDown) else $error("countdown wrong");
  property p_expire;
    (s_freeTick and startOut && remainQ == 20'sd1) |=> busXfmrFailure != lineXfmrFailure;
  endproperty
  a_expire: assert property (p_expire) else $error("no failure at expiry");
  property p_fuse;
    (busChk && busTripSync) |=> busFuseFailure;
  endproperty
  a_fuse: assert property (p_fuse) else $error("bus fuse failure missing");
  property p_problem;
    (pickRaw && !busDead) |=> busVoltState == vxs_pkg::BUS_PROBLEM;
  endproperty
  a_problem: assert property (p_problem) else $error("problem status missing");
  property p_tickGap;
    tick |=> !tick ##0 (tickCntQ == TW'(0))[*1];
  endproperty
  a_tickGap: assert property (p_tickGap) else $error("time base restart wrong");
endmodule
`default_nettype wire

// *** test/voltage_transformer_supervision_test.sv ***
// self-checking bench for the supervision block
`timescale 1ns/100ps
`default_nettype none
module voltage_transformer_supervision_test;
  localparam int T = 20;
  localparam int D = 4;
  logic core_clk = 1'b0, arst_n = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [2:0] mode = 3'h0;
  logic [15:0] volt1Mag, volt2Mag, volt3Mag, volt4Mag, volt1Ang, volt2Ang, volt3Ang, volt4Ang;
  logic blockIn = 1'b0, busBreakerTripInput = 1'b0, lineBreakerTripInput = 1'b0;
  logic startOut, blockedOut, busXfmrFailure, lineXfmrFailure, busFuseFailure, lineFuseFailure;
  logic [2:0] busVoltState;
  logic [4:0] condState;
  logic [7:0] rAdr [4] = '{8'h00, 8'h04, 8'h08, 8'h0C};
  logic [31:0] rExp [4] = '{32'h00000006, 32'h00500005, 32'h000001F4, 32'h000000C8};
  int err_total = 0, checks = 0, cyc = 0, n;
  vxs_supervision #(.TICK_CYCLES(T)) dut (
    .core_clk, .arst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .volt1Mag, .volt2Mag, .volt3Mag, .volt4Mag, .volt1Ang, .volt2Ang,
    .volt3Ang, .volt4Ang, .blockIn, .busBreakerTripInput, .lineBreakerTripInput, .startOut,
    .blockedOut, .busXfmrFailure, .lineXfmrFailure, .busFuseFailure, .lineFuseFailure,
    .busVoltState, .condState);
  vxs_meas_model model (.core_clk, .mode, .volt1Mag, .volt2Mag, .volt3Mag, .volt4Mag,
    .volt1Ang, .volt2Ang, .volt3Ang, .volt4Ang);
  // 200 MHz clock
  always #2.5 core_clk = ~core_clk;
  // ---------------------------------------
  // tasks
  // ---------------------------------------
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic cmpWord(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  // write: address and data offered together, each dropped when taken
  task automatic axWrite(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ad, wd;
    @(posedge core_clk);
    ad = 1'b0;
    wd = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge core_clk);
      if (!ad && s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_awready === 1'b1) ad = 1'b1;
      if (!wd && s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      if (s_axi_wready === 1'b1) wd = 1'b1;
    end
    do @(posedge core_clk); while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic axRead(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge core_clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge core_clk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic waitState(input logic [2:0] e);
    for (n = 0; n < 8 * T && busVoltState !== e; n++) @(posedge core_clk);
    cmpWord("busVoltState", 32'(e), 32'(busVoltState));
  endtask
  // hang guard
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total = err_total + 1;
      summarize();
    end
  end
  // ---------------------------------------
  // tests
  // ---------------------------------------
  initial begin
    repeat (8) @(posedge core_clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    foreach (rAdr[i]) begin
      axRead(rAdr[i], rd, rsp);
      cmpWord("reset value", rExp[i], rd);
    end
    axRead(8'h28, rd, rsp);
    cmpWord("unmapped read resp", 32'(vxs_pkg::RESP_SLVERR), 32'(rsp));
    axWrite(vxs_pkg::OFF_STATUS, 32'h0, rsp);
    cmpWord("status write resp", 32'(vxs_pkg::RESP_SLVERR), 32'(rsp));
    axWrite(vxs_pkg::OFF_G0_THR, 32'h006E0005, rsp);
    axWrite(vxs_pkg::OFF_G0_DLY, 32'(D), rsp);
    $display("register test done");
    waitState(vxs_pkg::BUS_OK);
    mode <= 3'h1;
    waitState(vxs_pkg::BUS_REV);
    mode <= 3'h3;
    waitState(vxs_pkg::BUS_DEAD);
    mode <= 3'h0;
    axWrite(vxs_pkg::OFF_CTRL, 32'h7, rsp);
    waitState(vxs_pkg::BUS_PROBLEM);
    axWrite(vxs_pkg::OFF_CTRL, 32'h6, rsp);
    waitState(vxs_pkg::BUS_OK);
    $display("status test done");
    mode <= 3'h2;
    waitState(vxs_pkg::BUS_PROBLEM);
    for (n = 0; n < 4 * T && startOut !== 1'b1; n++) @(posedge core_clk);
    cmpWord("cond start", 32'(vxs_pkg::COND_START), 32'(condState));
    for (n = 0; n < 8 * T && busXfmrFailure !== 1'b1; n++) @(posedge core_clk);
    cmpWord("delay cycles", 32'(D * T), 32'(n));
    cmpWord("cond bus", 32'(vxs_pkg::COND_BUS), 32'(condState));
    cmpWord("line failure", 32'h0, 32'(lineXfmrFailure));
    axRead(vxs_pkg::OFF_EXPTIME, rd, rsp);
    cmpWord("expected time", 32'(D), rd);
    mode <= 3'h0;
    waitState(vxs_pkg::BUS_OK);
    $display("countdown test done");
    // let start drop and the angle history refill before the next fault
    repeat (12 * T) @(posedge core_clk);
    mode <= 3'h2;
    for (n = 0; n < 8 * T && startOut !== 1'b1; n++) @(posedge core_clk);
    blockIn <= 1'b1;
    for (n = 0; n < 4 * T && startOut !== 1'b0; n++) @(posedge core_clk);
    cmpWord("cond blocked", 32'(vxs_pkg::COND_BLOCKED), 32'(condState));
    repeat (D * T) @(posedge core_clk);
    cmpWord("start under block", 32'h0, 32'(startOut));
    cmpWord("failure under block", 32'h0, 32'(busXfmrFailure));
    blockIn <= 1'b0;
    mode <= 3'h0;
    $display("blocking test done");
    // skewed order in limits, then a lost phase with the line channel lost
    repeat (12 * T) @(posedge core_clk);
    mode <= 3'h4;
    waitState(vxs_pkg::BUS_UNDEF);
    mode <= 3'h5;
    for (n = 0; n < 8 * T && startOut !== 1'b1; n++) @(posedge core_clk);
    for (n = 0; n < 8 * T && lineXfmrFailure !== 1'b1; n++) @(posedge core_clk);
    cmpWord("line delay cycles", 32'(D * T), 32'(n));
    cmpWord("cond line", 32'(vxs_pkg::COND_LINE), 32'(condState));
    cmpWord("bus failure", 32'h0, 32'(busXfmrFailure));
    mode <= 3'h0;
    $display("line test done");
    busBreakerTripInput <= 1'b1;
    lineBreakerTripInput <= 1'b1;
    repeat (6) @(posedge core_clk);
    cmpWord("bus fuse", 32'h1, 32'(busFuseFailure));
    cmpWord("line fuse", 32'h1, 32'(lineFuseFailure));
    axWrite(vxs_pkg::OFF_CTRL, 32'h0, rsp);
    repeat (4) @(posedge core_clk);
    cmpWord("bus fuse off", 32'h0, 32'(busFuseFailure));
    cmpWord("line fuse off", 32'h0, 32'(lineFuseFailure));
    $display("fuse test done");
    summarize();
  end
endmodule
`default_nettype wire

// *** test/vxs_meas_model.sv ***
// measurement channel model feeding the supervision block
`timescale 1ns/100ps
`default_nettype none
module vxs_meas_model (
  input wire logic core_clk, // clock
  input wire logic [2:0] mode, // 0 fwd, 1 rev, 2 ch1 lost, 3 dead, 4 ch1 skew, 5 ch1+line lost
  output logic [15:0] volt1Mag, // ch1 magnitude
  output logic [15:0] volt2Mag, // ch2 magnitude
  output logic [15:0] volt3Mag, // ch3 magnitude
  output logic [15:0] volt4Mag, // line magnitude
  output logic [15:0] volt1Ang, // ch1 angle
  output logic [15:0] volt2Ang, // ch2 angle
  output logic [15:0] volt3Ang, // ch3 angle
  output logic [15:0] volt4Ang // line angle
);
  logic [2:0] modeQ = 3'h0;
  logic ch1Lost, ch1Skew;
  // scenario changes land just after an edge
  always @(posedge core_clk) modeQ <= mode;
  // nominal magnitude 1.00, forward order 0/240/120 deg, skewed ch1 jumps 40.96 deg
  assign ch1Lost = (modeQ == 3'h2) || (modeQ == 3'h3) || (modeQ == 3'h5);
  assign ch1Skew = (modeQ == 3'h2) || (modeQ == 3'h4) || (modeQ == 3'h5);
  assign volt1Mag = ch1Lost ? 16'h0000 : 16'h0064;
  assign volt2Mag = (modeQ == 3'h3) ? 16'h0000 : 16'h0064;
  assign volt3Mag = (modeQ == 3'h3) ? 16'h0000 : 16'h0064;
  assign volt4Mag = (modeQ == 3'h5) ? 16'h0000 : 16'h0064;
  assign volt1Ang = ch1Skew ? 16'h1000 : 16'h0000;
  assign volt2Ang = modeQ[0] ? 16'h2EE0 : 16'h5DC0;
  assign volt3Ang = modeQ[0] ? 16'h5DC0 : 16'h2EE0;
  assign volt4Ang = 16'h0000;
endmodule
`default_nettype wire
